// ===== verilog/dmc_regs.svh
// constants for the multiply, control and i/o decode block
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
// opcode patterns, word compares on the full instruction
`define DMC_OP_PROD_ACC_W 16'h7f8f
`define DMC_OP_PROD_COPY_W 16'h7f8e
`define DMC_OP_PROD_SUB_W 16'h7f90
`define DMC_OP_MAGN_W 16'h7f88
`define DMC_OP_IRQ_DIS_W 16'h7f81
`define DMC_OP_IRQ_EN_W 16'h7f82
`define DMC_OP_NOP_W 16'h7f80
`define DMC_OP_POP_W 16'h7f9d
`define DMC_OP_PUSH_W 16'h7f9c
`define DMC_OP_SAT_CLR_W 16'h7f8a
`define DMC_OP_SAT_SET_W 16'h7f8b
// upper-byte opcode patterns, bits 15..8
`define DMC_OP_FLOAD_B 8'h6a
`define DMC_OP_FLOAD_ACC_B 8'h6c
`define DMC_OP_FLOAD_SHIFT_B 8'h6b
`define DMC_OP_PROD_FORM_B 8'h6d
`define DMC_OP_FLAGS_RST_B 8'h7b
`define DMC_OP_FLAGS_SAV_B 8'h7c
`define DMC_OP_WSHIFT_B 8'h69
`define DMC_OP_PFETCH_B 8'h67
`define DMC_OP_PSTORE_B 8'h7d
`define DMC_OP_UPPER_ADD_B 8'h60
// group opcodes on the top bits: add bits 15..12, port in/out bits 15..11, immediate multiply bits 15..13
`define DMC_OP_ADD_N 4'h0
`define DMC_OP_IN_N 5'h08
`define DMC_OP_OUT_N 5'h09
`define DMC_OP_PROD_IMM_N 3'h4
// field position, saturation limits and stack depth
`define DMC_IND_BIT 7
`define DMC_MIN_NEG 32'h80000000
`define DMC_MAX_POS 32'h7fffffff
`define DMC_STACK_DEPTH 4
`endif

// ===== verilog/dmc_pkg.sv
// types for the multiply, control and i/o decode block
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_ST_IDLE = 2'b00,
    DMC_ST_EX2 = 2'b01,
    DMC_ST_EX3 = 2'b10
  } dmc_state_t;
endpackage : dmc_pkg

// ===== verilog/dmc_mult.sv
// registered signed 16x16 multiplier
`timescale 1ns/1ps
module dmc_mult #(
  parameter int W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic signed [W-1:0] a_i,
  input wire logic signed [W-1:0] b_i,
  output logic signed [2*W-1:0] p_o
);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p_o <= '0;
    end else if (load_i) begin
      p_o <= a_i * b_i;
    end
  end
endmodule : dmc_mult

// ===== verilog/dmc_stack.sv
// small hardware stack of words, top held in a register
`timescale 1ns/1ps
module dmc_stack #(
  parameter int W = 12,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] top_o
);
  logic [W-1:0] mem_q [DEPTH];
  // overflow drops the bottom entry, underflow repeats it, like a shift chain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push_i) begin
      mem_q[0] <= din_i;
      for (int i = 1; i < DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_q[i] <= mem_q[i+1];
      end
    end
  end
  assign top_o = mem_q[0];
endmodule : dmc_stack

// ===== verilog/dmc_core.sv
// decode and execute for multiply, control, i/o and table instructions
`timescale 1ns/1ps
`include "dmc_regs.svh"

// Overview of operation
// - product accumulate adds product into sum
// - accumulating factor load also adds old product into sum
// - factor load, accumulate, and shift word up
// - multiply factor by data word into product
// - multiply factor by immediate constant field
// - copy product register into sum register
// - subtract product register from sum register
// - clear and set saturation mode opcodes
// - restore flags from memory, save flags
// - stack take and put, two cycles
// - copy data word to next address
// - port read and write, two cycles
// - program word fetch and store, three cycles
// - magnitude negates negative sum register
// - most negative magnitude saturates when enabled
// - shifted data word added to sum
// - data word added to upper half
module dmc_core
  import dmc_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 8,
  parameter int PW = 12,
  parameter int STACK_DEPTH = `DMC_STACK_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic [DW-1:0] instr_i,
  output logic instr_ready_o,
  // addressing context
  input wire logic [6:0] data_page_dma_i,
  input wire logic [AW-1:0] aux_reg_i,
  input wire logic [PW-1:0] table_addr_i,
  // data memory
  input wire logic [DW-1:0] dmem_rdata_i,
  output logic [AW-1:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic [DW-1:0] dmem_wdata_o,
  // program memory table access
  input wire logic [DW-1:0] pmem_rdata_i,
  output logic [PW-1:0] pmem_addr_o,
  output logic pmem_we_o,
  output logic [DW-1:0] pmem_wdata_o,
  // ports
  input wire logic [DW-1:0] port_rdata_i,
  output logic [2:0] port_number_o,
  output logic port_rd_o,
  output logic port_wr_o,
  output logic [DW-1:0] port_wdata_o,
  // state visible outside
  output logic [31:0] sum_register_o,
  output logic [31:0] product_o,
  output logic [DW-1:0] factor_o,
  output logic saturation_mode_o,
  output logic irq_enable_o,
  output logic overflow_o
);
  // ==========================================================
  // decode
  logic [7:0] hi_b;
  logic is_prod_acc;
  logic is_prod_copy;
  logic is_prod_sub;
  logic is_magn;
  logic is_irq_dis;
  logic is_irq_en;
  logic is_pop;
  logic is_push;
  logic is_sat_clr;
  logic is_sat_set;
  logic is_fload;
  logic is_fload_acc;
  logic is_fload_shift;
  logic is_prod_form;
  logic is_prod_imm;
  logic is_flags_rst;
  logic is_flags_sav;
  logic is_wshift;
  logic is_pfetch;
  logic is_pstore;
  logic is_upper_add;
  logic is_add;
  logic is_in;
  logic is_out;
  logic [AW-1:0] ea;
  dmc_state_t state_q;
  logic [DW-1:0] instr_q;
  logic [AW-1:0] ea_q;

  assign hi_b = instr_i[15:8];
  assign is_prod_acc = instr_i == `DMC_OP_PROD_ACC_W;
  assign is_prod_copy = instr_i == `DMC_OP_PROD_COPY_W;
  assign is_prod_sub = instr_i == `DMC_OP_PROD_SUB_W;
  assign is_magn = instr_i == `DMC_OP_MAGN_W;
  assign is_irq_dis = instr_i == `DMC_OP_IRQ_DIS_W;
  assign is_irq_en = instr_i == `DMC_OP_IRQ_EN_W;
  assign is_pop = instr_i == `DMC_OP_POP_W;
  assign is_push = instr_i == `DMC_OP_PUSH_W;
  assign is_sat_clr = instr_i == `DMC_OP_SAT_CLR_W;
  assign is_sat_set = instr_i == `DMC_OP_SAT_SET_W;
  assign is_fload = hi_b == `DMC_OP_FLOAD_B;
  assign is_fload_acc = hi_b == `DMC_OP_FLOAD_ACC_B;
  assign is_fload_shift = hi_b == `DMC_OP_FLOAD_SHIFT_B;
  assign is_prod_form = hi_b == `DMC_OP_PROD_FORM_B;
  assign is_prod_imm = instr_i[15:13] == `DMC_OP_PROD_IMM_N;
  assign is_flags_rst = hi_b == `DMC_OP_FLAGS_RST_B;
  assign is_flags_sav = hi_b == `DMC_OP_FLAGS_SAV_B;
  assign is_wshift = hi_b == `DMC_OP_WSHIFT_B;
  assign is_pfetch = hi_b == `DMC_OP_PFETCH_B;
  assign is_pstore = hi_b == `DMC_OP_PSTORE_B;
  assign is_upper_add = hi_b == `DMC_OP_UPPER_ADD_B;
  assign is_add = instr_i[15:12] == `DMC_OP_ADD_N;
  assign is_in = instr_i[15:11] == `DMC_OP_IN_N;
  assign is_out = instr_i[15:11] == `DMC_OP_OUT_N;

  // direct uses the low seven bits, indirect the auxiliary register
  assign ea = instr_i[`DMC_IND_BIT] ? aux_reg_i
            : AW'({data_page_dma_i[6:7-1] & 1'b0, instr_i[6:0]});

  logic take;
  assign take = instr_valid_i && (state_q == DMC_ST_IDLE);

  // ==========================================================
  // multiplier and stack
  logic mult_load;
  logic signed [DW-1:0] mult_b;
  logic [31:0] stack_top;
  assign mult_load = take && (is_prod_form || is_prod_imm);
  // immediate constant is a 13-bit signed field
  assign mult_b = is_prod_imm ? DW'(signed'(instr_i[12:0])) : dmem_rdata_i;
  // sum ops read the product one instruction after it is formed
  dmc_mult #(.W(DW)) u_mult (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(mult_load),
    .a_i(factor_o),
    .b_i(mult_b),
    .p_o(product_o)
  );

  // stack moves in the second cycle, after the sum has settled
  logic stk_push, stk_pop;
  assign stk_push = (state_q == DMC_ST_EX2) && (instr_q == `DMC_OP_PUSH_W);
  assign stk_pop = (state_q == DMC_ST_EX2) && (instr_q == `DMC_OP_POP_W);
  dmc_stack #(.W(32), .DEPTH(STACK_DEPTH)) u_stack (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .push_i(stk_push),
    .pop_i(stk_pop),
    .din_i(sum_register_o),
    .top_o(stack_top)
  );

  // ==========================================================
  // sequencing of multi-cycle operations
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= DMC_ST_IDLE;
      instr_q <= '0;
      ea_q <= '0;
    end else begin
      case (state_q)
        DMC_ST_IDLE: begin
          if (take) begin
            instr_q <= instr_i;
            ea_q <= ea;
            if (is_pfetch || is_pstore) begin
              state_q <= DMC_ST_EX3;
            end else if (is_pop || is_push || is_in || is_out) begin
              state_q <= DMC_ST_EX2;
            end
          end
        end
        DMC_ST_EX3: state_q <= DMC_ST_EX2;
        DMC_ST_EX2: state_q <= DMC_ST_IDLE;
        default: state_q <= DMC_ST_IDLE;
      endcase
    end
  end

  logic start_long;
  assign start_long = take && (is_pfetch || is_pstore || is_pop || is_push || is_in || is_out);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_ready_o <= 1'b0;
    end else begin
      // ready only when the next cycle is free to take a word
      instr_ready_o <= (state_q == DMC_ST_IDLE) ? !start_long : (state_q == DMC_ST_EX2);
    end
  end

  // ==========================================================
  // sum register arithmetic
  logic [32:0] sum_n;
  logic [31:0] sum_nx;
  logic sum_we, sat_ovf;
  logic signed [31:0] shifted;
  always_comb begin
    sum_n = {1'b0, sum_register_o};
    sum_we = 1'b0;
    shifted = 32'(signed'(dmem_rdata_i)) <<< instr_i[11:8];
    if (take && (is_prod_acc || is_fload_acc || is_fload_shift)) begin
      sum_n = {sum_register_o[31], sum_register_o} + {product_o[31], product_o};
      sum_we = 1'b1;
    end else if (take && is_prod_sub) begin
      sum_n = {sum_register_o[31], sum_register_o} - {product_o[31], product_o};
      sum_we = 1'b1;
    end else if (take && is_prod_copy) begin
      sum_n = {product_o[31], product_o};
      sum_we = 1'b1;
    end else if (take && is_magn) begin
      sum_n = sum_register_o[31] ? 33'h0 - {sum_register_o[31], sum_register_o}
            : {1'b0, sum_register_o};
      sum_we = 1'b1;
    end else if (take && is_add) begin
      sum_n = {sum_register_o[31], sum_register_o} + {shifted[31], shifted};
      sum_we = 1'b1;
    end else if (take && is_upper_add) begin
      sum_n = {sum_register_o[31], sum_register_o}
            + {dmem_rdata_i[15], dmem_rdata_i, 16'h0000};
      sum_we = 1'b1;
    end else if (stk_pop) begin
      sum_n = {stack_top[31], stack_top};
      sum_we = 1'b1;
    end
    // clamping applies to every sum update, a stack take included
    sat_ovf = sum_n[32] != sum_n[31];
    sum_nx = sum_n[31:0];
    if (sat_ovf && saturation_mode_o) begin
      sum_nx = sum_n[32] ? `DMC_MIN_NEG : `DMC_MAX_POS;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_register_o <= '0;
      overflow_o <= 1'b0;
    end else if (sum_we) begin
      sum_register_o <= sum_nx;
      overflow_o <= overflow_o | sat_ovf;
    end else if (take && is_flags_rst) begin
      overflow_o <= dmem_rdata_i[15];
    end
  end

  // ==========================================================
  // factor register and mode bits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      factor_o <= '0;
    end else if (take && (is_fload || is_fload_acc || is_fload_shift)) begin
      factor_o <= dmem_rdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      saturation_mode_o <= 1'b0;
      irq_enable_o <= 1'b0;
    end else if (take) begin
      if (is_sat_clr) begin
        saturation_mode_o <= 1'b0;
      end
      if (is_sat_set) begin
        saturation_mode_o <= 1'b1;
      end
      if (is_irq_dis) begin
        irq_enable_o <= 1'b0;
      end
      if (is_irq_en) begin
        irq_enable_o <= 1'b1;
      end
      if (is_flags_rst) begin
        saturation_mode_o <= dmem_rdata_i[13];
        irq_enable_o <= !dmem_rdata_i[12];
      end
    end
  end

  // ==========================================================
  // memory, port and table strobes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dmem_addr_o <= '0;
      dmem_we_o <= 1'b0;
      dmem_wdata_o <= '0;
      pmem_addr_o <= '0;
      pmem_we_o <= 1'b0;
      pmem_wdata_o <= '0;
      port_number_o <= '0;
      port_rd_o <= 1'b0;
      port_wr_o <= 1'b0;
      port_wdata_o <= '0;
    end else begin
      dmem_we_o <= 1'b0;
      pmem_we_o <= 1'b0;
      port_rd_o <= 1'b0;
      port_wr_o <= 1'b0;
      // port read and table read end with a data write to the held address
      if (take && (is_wshift || is_fload_shift)) begin
        dmem_addr_o <= ea + 1'b1;
        dmem_wdata_o <= dmem_rdata_i;
        dmem_we_o <= 1'b1;
      end else if (take && is_flags_sav) begin
        dmem_addr_o <= ea;
        dmem_wdata_o <= {overflow_o, 1'b0, saturation_mode_o, !irq_enable_o, 12'h000};
        dmem_we_o <= 1'b1;
      end else if (take && (is_in || is_out)) begin
        port_number_o <= instr_i[10:8];
        port_rd_o <= is_in;
        port_wr_o <= is_out;
        port_wdata_o <= dmem_rdata_i;
      end else if (state_q == DMC_ST_EX2 && instr_q[15:11] == `DMC_OP_IN_N) begin
        dmem_addr_o <= ea_q;
        dmem_wdata_o <= port_rdata_i;
        dmem_we_o <= 1'b1;
      end else if (take && (is_pfetch || is_pstore)) begin
        pmem_addr_o <= table_addr_i;
        pmem_wdata_o <= dmem_rdata_i;
        pmem_we_o <= is_pstore;
      end else if (state_q == DMC_ST_EX2 && instr_q[15:8] == `DMC_OP_PFETCH_B) begin
        dmem_addr_o <= ea_q;
        dmem_wdata_o <= pmem_rdata_i;
        dmem_we_o <= 1'b1;
      end
    end
  end
endmodule : dmc_core

// ===== test/dmc_core_chk.sv
// port assertions for the multiply, control and i/o decode core
`timescale 1ns/1ps
// ==========
// checker
module dmc_core_chk (
  // clock, reset and instruction stream
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_ready_o,
  // data side
  input wire logic [15:0] dmem_rdata_i,
  input wire logic [15:0] port_rdata_i,
  input wire logic dmem_we_o,
  input wire logic [15:0] dmem_wdata_o,
  input wire logic [2:0] port_number_o,
  input wire logic port_rd_o,
  // state
  input wire logic [31:0] sum_register_o,
  input wire logic [31:0] product_o,
  input wire logic [15:0] factor_o,
  input wire logic saturation_mode_o,
  input wire logic irq_enable_o
);
  logic tk;
  logic [31:0] s;
  logic signed [31:0] fx;
  logic signed [31:0] dx;
  assign tk = instr_valid_i && instr_ready_o;
  assign s = sum_register_o;
  // widen first so the product keeps its sign in an unsigned compare
  assign fx = $signed(factor_o);
  assign dx = $signed(dmem_rdata_i);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  pacc_sum_a: assert property (tk && instr_i == 16'h7f8f && !saturation_mode_o
    |=> s == $past(s) + $past(product_o)) else $error("accumulate result wrong");
  pcopy_sum_a: assert property (tk && instr_i == 16'h7f8e
    |=> s == $past(product_o)) else $error("product copy wrong");
  mult_prod_a: assert property (tk && instr_i[15:8] == 8'h6d
    |=> product_o == $past(fx) * $past(dx)) else $error("product wrong");
  mag_plain_a: assert property (tk && instr_i == 16'h7f88 && !saturation_mode_o
    |=> s == ($past(s[31]) ? -$past(s) : $past(s))) else $error("magnitude wrong");
  mag_sat_a: assert property (tk && instr_i == 16'h7f88 && saturation_mode_o
    && s == 32'h80000000 |=> s == 32'h7fffffff) else $error("magnitude not saturated");
  sat_mode_a: assert property (tk && instr_i[15:1] == 15'h3fc5
    |=> saturation_mode_o == $past(instr_i[0])) else $error("saturation mode wrong");
  irq_latch_a: assert property (tk && (instr_i == 16'h7f81 || instr_i == 16'h7f82)
    |=> irq_enable_o == $past(instr_i[1])) else $error("interrupt latch wrong");
  port_in_a: assert property (tk && instr_i[15:11] == 5'h08
    |=> port_rd_o && !instr_ready_o && port_number_o == $past(instr_i[10:8])
    ##1 dmem_we_o && dmem_wdata_o == $past(port_rdata_i)) else $error("port read wrong");
  stack_busy_a: assert property (tk && instr_i[15:1] == 15'h3fce
    |=> !instr_ready_o) else $error("stack op not two cycles");
  upper_half_sum_op_low_a: assert property (tk && instr_i[15:8] == 8'h60 && !saturation_mode_o
    |=> s == $past(s) + {$past(dmem_rdata_i), 16'h0000}) else $error("upper add wrong");
endmodule : dmc_core_chk

bind dmc_core dmc_core_chk u_chk (.sys_clk_i, .rst_n_i, .instr_valid_i, .instr_i,
  .instr_ready_o, .dmem_rdata_i, .port_rdata_i, .dmem_we_o, .dmem_wdata_o, .port_number_o,
  .port_rd_o, .sum_register_o, .product_o, .factor_o, .saturation_mode_o, .irq_enable_o);

// ===== test/dmc_far_model.sv
// far-side model: program memory, port peripherals and a log of writes
`timescale 1ns/1ps
// ==========
// model
module dmc_far_model (
  // clock and core outputs
  input wire logic sys_clk_i,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_addr_i,
  input wire logic [15:0] dm_wdata_i,
  input wire logic [11:0] pm_addr_i,
  input wire logic pm_we_i,
  input wire logic [15:0] pm_wdata_i,
  input wire logic [2:0] pt_num_i,
  input wire logic pt_rd_i,
  input wire logic pt_wr_i,
  input wire logic [15:0] pt_wdata_i,
  // answers and log
  output logic [15:0] pm_rdata_o,
  output logic [15:0] pt_rdata_o,
  output logic [1:0] kind_o,
  output logic [11:0] addr_o,
  output logic [15:0] data_o,
  output logic [7:0] ev_o
);
  assign pm_rdata_o = {4'h5, pm_addr_i};
  // port lines float outside a read: show the inverse so stale data cannot match
  assign pt_rdata_o = pt_rd_i ? {13'h1e1e, pt_num_i} : ~{13'h1e1e, pt_num_i};
  initial ev_o = 8'h00;
  always @(posedge sys_clk_i) begin
    if (dm_we_i || pm_we_i || pt_wr_i) begin
      ev_o <= ev_o + 8'h01;
      kind_o <= dm_we_i ? 2'h1 : (pm_we_i ? 2'h2 : 2'h3);
      addr_o <= dm_we_i ? {4'h0, dm_addr_i} : (pm_we_i ? pm_addr_i : {9'h000, pt_num_i});
      data_o <= dm_we_i ? dm_wdata_i : (pm_we_i ? pm_wdata_i : pt_wdata_i);
    end
  end
endmodule : dmc_far_model

// ===== test/test_dmc_core.sv
// self-checking bench for the multiply, control and i/o decode core
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
// ==========
// bench
module test_dmc_core;
  logic sys_clk_i, rst_n_i, instr_valid_i, instr_ready_o, dmem_we_o, pmem_we_o;
  logic [15:0] instr_i, dmem_rdata_i, pmem_rdata_i, port_rdata_i, dmem_wdata_o;
  logic [15:0] pmem_wdata_o, port_wdata_o, factor_o, data;
  logic [6:0] data_page_dma_i;
  logic [7:0] aux_reg_i, dmem_addr_o, ev, snap;
  logic [11:0] table_addr_i, pmem_addr_o, addr;
  logic [2:0] port_number_o;
  logic port_rd_o, port_wr_o, saturation_mode_o, irq_enable_o, overflow_o;
  logic [31:0] sum_register_o, product_o;
  logic [1:0] kind;
  int err_total = 0;
  int check_count = 0;
  dmc_core dut (.sys_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .instr_ready_o,
    .data_page_dma_i, .aux_reg_i, .table_addr_i, .dmem_rdata_i, .dmem_addr_o, .dmem_we_o,
    .dmem_wdata_o, .pmem_rdata_i, .pmem_addr_o, .pmem_we_o, .pmem_wdata_o, .port_rdata_i,
    .port_number_o, .port_rd_o, .port_wr_o, .port_wdata_o, .sum_register_o, .product_o,
    .factor_o, .saturation_mode_o, .irq_enable_o, .overflow_o);
  dmc_far_model far (.sys_clk_i, .dm_we_i(dmem_we_o), .dm_addr_i(dmem_addr_o),
    .dm_wdata_i(dmem_wdata_o), .pm_addr_i(pmem_addr_o), .pm_we_i(pmem_we_o),
    .pm_wdata_i(pmem_wdata_o), .pt_num_i(port_number_o), .pt_rd_i(port_rd_o),
    .pt_wr_i(port_wr_o), .pt_wdata_i(port_wdata_o), .pm_rdata_o(pmem_rdata_i),
    .pt_rdata_o(port_rdata_i), .kind_o(kind), .addr_o(addr), .data_o(data), .ev_o(ev));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // issue one word; returns at the edge where the next word may be offered
  task automatic run(input logic [15:0] w, input logic [15:0] d, input int n);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    dmem_rdata_i <= d;
    snap = ev;
    @(posedge sys_clk_i);
    if (n > 1) begin
      instr_valid_i <= 1'b0;
      dmem_rdata_i <= ~d;
      repeat (n - 1) @(posedge sys_clk_i);
    end
  endtask : run
  task automatic idle();
    instr_valid_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : idle
  task automatic wait_ev();
    int k;
    instr_valid_i <= 1'b0;
    for (k = 0; k < 8 && ev == snap; k++) @(posedge sys_clk_i);
    if (ev == snap) begin
      err_total++;
      end_sim();
    end
  endtask : wait_ev
  initial begin
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h7f80;
    dmem_rdata_i = 16'h0000;
    data_page_dma_i = 7'h00;
    aux_reg_i = 8'h40;
    table_addr_i = 12'h000;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    `CHK("ready", 1'b1, instr_ready_o)
    `CHK("sum", 32'h0, sum_register_o)
    run(16'h6005, 16'h8000, 1);
    idle();
    `CHK("sum", 32'h80000000, sum_register_o)
    run(16'h7f88, 16'h0000, 1);
    idle();
    `CHK("sum", 32'h80000000, sum_register_o)
    run(16'h7f8b, 16'h0000, 1);
    run(16'h7f88, 16'h0000, 1);
    idle();
    `CHK("sat", 1'b1, saturation_mode_o)
    `CHK("sum", 32'h7fffffff, sum_register_o)
    run(16'h7f8a, 16'h0000, 1);
    run(16'h6a05, 16'hfffd, 1);
    run(16'h6d05, 16'h0007, 1);
    idle();
    `CHK("sat", 1'b0, saturation_mode_o)
    `CHK("product", 32'hffffffeb, product_o)
    run(16'h7f8e, 16'h0000, 1);
    run(16'h7f8f, 16'h0000, 1);
    idle();
    `CHK("sum", 32'hffffffd6, sum_register_o)
    run(16'h7f90, 16'h0000, 1);
    run(16'h9fff, 16'h0000, 1);
    idle();
    `CHK("sum", 32'hffffffeb, sum_register_o)
    `CHK("product", 32'h00000003, product_o)
    run(16'h6c05, 16'h0002, 1);
    idle();
    `CHK("sum", 32'hffffffee, sum_register_o)
    run(16'h6b85, 16'h0010, 1);
    wait_ev();
    `CHK("ltd addr", 12'h041, addr)
    `CHK("sum", 32'hfffffff1, sum_register_o)
    `CHK("factor", 16'h0010, factor_o)
    run(16'h6905, 16'h1234, 1);
    wait_ev();
    `CHK("move", {12'h006, 16'h1234}, {addr, data})
    run(16'h0f05, 16'h0001, 1);
    run(16'h0405, 16'h8b0e, 1);
    run(16'h7f82, 16'h0000, 1);
    idle();
    `CHK("sum", 32'hfff930d1, sum_register_o)
    `CHK("irq", 1'b1, irq_enable_o)
    run(16'h7f81, 16'h0000, 1);
    run(16'h7c05, 16'h0000, 1);
    wait_ev();
    `CHK("irq", 1'b0, irq_enable_o)
    `CHK("status", {12'h005, 16'h1000}, {addr, data & 16'h3000})
    run(16'h7b05, 16'h2000, 1);
    idle();
    `CHK("restore", 2'b11, {saturation_mode_o, irq_enable_o})
    `CHK("ovf", 1'b0, overflow_o)
    run(16'h7f8a, 16'h0000, 1);
    run(16'h7f80, 16'h0000, 1);
    run(16'h7f9c, 16'h0000, 2);
    run(16'h7f8e, 16'h0000, 1);
    run(16'h7f9d, 16'h0000, 2);
    idle();
    `CHK("sum", 32'hfff930d1, sum_register_o)
    run(16'h4305, 16'h0000, 2);
    wait_ev();
    `CHK("in", {2'h1, 12'h005, 16'hf0f3}, {kind, addr, data})
    run(16'h4e07, 16'hbeef, 2);
    wait_ev();
    `CHK("out", {2'h3, 12'h006, 16'hbeef}, {kind, addr, data})
    table_addr_i <= 12'h123;
    run(16'h6705, 16'h0000, 3);
    wait_ev();
    `CHK("fetch", {2'h1, 12'h005, 16'h5123}, {kind, addr, data})
    table_addr_i <= 12'h0ab;
    run(16'h7d05, 16'h4444, 3);
    wait_ev();
    `CHK("store", {2'h2, 12'h0ab, 16'h4444}, {kind, addr, data})
    end_sim();
  end
endmodule : test_dmc_core
